// file: logic/ias_cfg.svh
// Register map, field positions, reset values and bus codes of the acquisition sequencer
// Assumes inclusion by bare name from each design file that needs it
`ifndef IAS_CFG_SVH
`define IAS_CFG_SVH

// ==========================================================
// Register byte offsets
`define IAS_OFF_CTRL        12'h000
`define IAS_OFF_EXPTIME     12'h004
`define IAS_OFF_FRAMETIME   12'h008
`define IAS_OFF_FRAMECNT    12'h00c
`define IAS_OFF_STATUS      12'h010
`define IAS_OFF_GLOBTIME    12'h014

// ==========================================================
// Control field positions
`define IAS_CTRL_MODE_BIT   0
`define IAS_CTRL_SINGLE_BIT 1
`define IAS_CTRL_SW_BIT     2
`define IAS_CTRL_CMD1_BIT   8
`define IAS_CTRL_CMD2_BIT   9

// ==========================================================
// Status field positions
`define IAS_ST_EXPOSE_BIT   0
`define IAS_ST_SAMPLE_BIT   1
`define IAS_ST_READ_BIT     2
`define IAS_ST_ACTIVE_BIT   3
`define IAS_ST_CORRUPT_BIT  4
`define IAS_ST_HOLD_BIT     5
`define IAS_ST_FREAD_LSB    8
`define IAS_ST_SEQLEN_LSB   16

// ==========================================================
// Reset values, in clock cycles where a time, and the sequence length cap
`define IAS_CTRL_RST        32'h0000_0000
`define IAS_EXPTIME_RST     32'h0000_03e8
`define IAS_FRAMETIME_RST   32'h0000_0fa0
`define IAS_FRAMECNT_RST    8'h01
`define IAS_GLOBTIME_RST    32'h0000_0040
`define IAS_SEQ_MAX         8'hff

// ==========================================================
// AXI4-Lite response codes
`define IAS_RESP_OKAY       2'b00
`define IAS_RESP_SLVERR     2'b10

`endif

// file: logic/ias_pkg.sv
// Types shared by the acquisition sequencer files
// Assumes nothing beyond a SystemVerilog compiler
package ias_pkg;

    // ==========================================================
    // Sampling and readout pipeline states
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_GLOB,
        PS_READ,
        PS_HOLD
    } ias_pipe_t;

    typedef logic [31:0] ias_word_t;

endpackage : ias_pkg

// file: logic/ias_req_edge.sv
// Request source: pin synchroniser, source select and edge detection
// Assumes pin is asynchronous to sys_clk and the register bit is not
`timescale 1ns/100ps
module ias_req_edge (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Sources
    input  wire logic pinAsync,
    input  wire logic regBit,
    input  wire logic useReg,
    // Edge pulses
    output logic      rise,
    output logic      fall
);
    logic pinMeta_ff;
    logic pinSync_ff;
    logic srcLast_ff;
    wire  srcNow = useReg ? regBit : pinSync_ff;

    // ==========================================================
    // Synchroniser and last value
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pinMeta_ff <= 1'b0;
            pinSync_ff <= 1'b0;
            srcLast_ff <= 1'b0;
        end
        else
        begin
            pinMeta_ff <= pinAsync;
            pinSync_ff <= pinMeta_ff;
            srcLast_ff <= srcNow;
        end
    end

    // Switching source may fake one edge; software switches while idle
    assign rise = srcNow & ~srcLast_ff;
    assign fall = ~srcNow & srcLast_ff;
endmodule : ias_req_edge

// file: logic/ias_sequencer.sv
// Acquisition sequencer: exposure, sampling and readout control with AXI4-Lite registers
// Assumes an AXI4-Lite master on sys_clk and a readout datapath giving a done strobe
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ias_cfg.svh"
module ias_sequencer (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset,
    // AXI4-Lite write address and data
    input  wire logic [11:0]     s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire ias_pkg::ias_word_t s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0]     s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output ias_pkg::ias_word_t   s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // Request pins
    input  wire logic            reqPin1,
    input  wire logic            reqPin2,
    // Readout datapath
    input  wire logic            readoutDone,
    // Sensor array control
    output logic                 exposing,
    output logic                 pixelReset,
    output logic                 sampling,
    output logic                 readingOut,
    output logic                 readoutStart,
    output logic                 readoutAbort,
    output logic                 frameCorrupt,
    output logic                 seqActive
);
    import ias_pkg::*;

    // ==========================================================
    // Registers
    ias_word_t ctrl_ff, expTime_ff, frameTime_ff, globTime_ff;
    logic [7:0] frameCnt_ff;
    logic       awReady_ff, wReady_ff, bValid_ff, arReady_ff, rValid_ff;
    logic [11:0] awAddr_ff;
    ias_word_t  wData_ff, rData_ff;
    logic [3:0] wStrb_ff;
    logic [1:0] bResp_ff, rResp_ff;

    // ==========================================================
    // Sequencer state
    ias_pipe_t  pipe_ff, nxtPipe;
    logic       expOn_ff, nxtExpOn;
    logic       expSeen_ff, nxtExpSeen;
    logic       corruptPend_ff, nxtCorruptPend;
    logic       corruptOut_ff, nxtCorruptOut;
    logic       active_ff, nxtActive;
    logic       lastRead_ff, nxtLastRead;
    ias_word_t  expCnt_ff, nxtExpCnt, globCnt_ff, nxtGlobCnt, frameTimer_ff, nxtFrameTimer;
    logic [7:0] seqLen_ff, nxtSeqLen, started_ff, nxtStarted, framesRead_ff, nxtFramesRead;
    logic       nxtPixReset, nxtReadStart, nxtAbort;
    logic       pixReset_ff, readStart_ff, abort_ff, sampling_ff, reading_ff;

    // ==========================================================
    // Request sources
    logic [1:0] reqRise, reqFall;
    wire  [1:0] reqPins = {reqPin2, reqPin1};
    wire  [1:0] cmdBits = {ctrl_ff[`IAS_CTRL_CMD2_BIT], ctrl_ff[`IAS_CTRL_CMD1_BIT]};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_req
            ias_req_edge u_edge (
                .sys_clk  (sys_clk),
                .reset    (reset),
                .pinAsync (reqPins[gi]),
                .regBit   (cmdBits[gi]),
                .useReg   (ctrl_ff[`IAS_CTRL_SW_BIT]),
                .rise     (reqRise[gi]),
                .fall     (reqFall[gi])
            );
        end
    endgenerate

    wire modeInt   = ctrl_ff[`IAS_CTRL_MODE_BIT];
    wire singlePin = ctrl_ff[`IAS_CTRL_SINGLE_BIT];
    wire expReq    = reqRise[0];
    wire frameRaw  = singlePin ? reqFall[0] : reqRise[1];
    wire frameReq  = frameRaw & ~modeInt;

    // ==========================================================
    // Timing decodes, 33 bits so a saturated count or a summed window cannot wrap
    wire globDone  = ({1'b0, globCnt_ff} + 33'd1) >= {1'b0, globTime_ff};
    wire expDone   = expOn_ff && (({1'b0, expCnt_ff} + 33'd1) >= {1'b0, expTime_ff});
    wire frameDue  = ({1'b0, frameTimer_ff} + 33'd1) >= {1'b0, frameTime_ff};
    wire startWin  = ({1'b0, frameTimer_ff} + {1'b0, expTime_ff} + 33'd1) >= {1'b0, frameTime_ff};
    wire moreDue   = started_ff < seqLen_ff;
    wire [8:0] seqSum = {1'b0, seqLen_ff} + {1'b0, frameCnt_ff};
    wire [7:0] seqSat = seqSum[8] ? `IAS_SEQ_MAX : seqSum[7:0];

    // ==========================================================
    // Sequencer next state
    always_comb
    begin
        nxtPipe        = pipe_ff;
        nxtExpOn       = expOn_ff;
        nxtExpSeen     = expSeen_ff;
        nxtCorruptPend = corruptPend_ff;
        nxtCorruptOut  = corruptOut_ff;
        nxtActive      = active_ff;
        nxtLastRead    = lastRead_ff;
        nxtExpCnt      = expOn_ff ? expCnt_ff + 32'h1 : expCnt_ff;
        nxtGlobCnt     = globCnt_ff + 32'h1;
        nxtFrameTimer  = (&frameTimer_ff) ? frameTimer_ff : frameTimer_ff + 32'h1;
        nxtSeqLen      = seqLen_ff;
        nxtStarted     = started_ff;
        nxtFramesRead  = framesRead_ff;
        nxtPixReset    = 1'b0;
        nxtReadStart   = 1'b0;
        nxtAbort       = 1'b0;
        if (!modeInt)
        begin
            if (pipe_ff == PS_GLOB && globDone)
            begin
                nxtPipe       = PS_READ;
                nxtReadStart  = 1'b1;
                nxtCorruptOut = corruptPend_ff;
            end
            // Exposure keeps running across readout completion
            if ((pipe_ff == PS_READ || pipe_ff == PS_HOLD) && readoutDone)
                nxtPipe = PS_IDLE;
            if (frameReq)
            begin
                nxtPipe        = PS_GLOB;
                nxtGlobCnt     = 32'h0;
                nxtExpOn       = 1'b0;
                nxtCorruptPend = !expSeen_ff || pipe_ff == PS_GLOB;
                nxtAbort       = pipe_ff == PS_READ;
                nxtExpSeen     = 1'b0;
            end
            if (expReq)
            begin
                nxtExpOn    = 1'b1;
                nxtExpCnt   = 32'h0;
                nxtPixReset = 1'b1;
                nxtExpSeen  = 1'b1;
                if (nxtPipe == PS_GLOB)
                    nxtCorruptPend = 1'b1;
            end
        end
        else
        begin
            nxtCorruptOut  = 1'b0;
            nxtCorruptPend = 1'b0;
            if (pipe_ff == PS_GLOB && globDone)
            begin
                nxtPipe      = PS_READ;
                nxtReadStart = 1'b1;
                nxtLastRead  = !moreDue && !expOn_ff;
            end
            if (pipe_ff == PS_READ && readoutDone)
            begin
                nxtFramesRead = framesRead_ff + 8'h1;
                nxtPipe       = lastRead_ff ? PS_HOLD : PS_IDLE;
            end
            if (pipe_ff == PS_HOLD && frameDue)
            begin
                nxtPipe     = PS_IDLE;
                nxtLastRead = 1'b0;
                nxtActive   = moreDue || expOn_ff;
            end
            // Expiry waits for the readout done strobe, so no frame is lost and no idle gap
            if (expDone && pipe_ff != PS_GLOB && (pipe_ff != PS_READ || readoutDone))
            begin
                nxtExpOn      = 1'b0;
                nxtPipe       = PS_GLOB;
                nxtGlobCnt    = 32'h0;
                nxtFrameTimer = 32'h0;
            end
            else if (active_ff && moreDue && !expOn_ff && pipe_ff != PS_GLOB && startWin)
            begin
                nxtExpOn    = 1'b1;
                nxtExpCnt   = 32'h0;
                nxtPixReset = 1'b1;
                nxtStarted  = started_ff + 8'h1;
            end
            if (expReq && !active_ff)
            begin
                nxtActive     = 1'b1;
                nxtSeqLen     = frameCnt_ff;
                nxtStarted    = 8'h1;
                nxtFramesRead = 8'h0;
                nxtExpOn      = 1'b1;
                nxtExpCnt     = 32'h0;
                nxtPixReset   = 1'b1;
            end
            else if (expReq && !lastRead_ff)
                nxtSeqLen = seqSat;
            else if (expReq)
            begin
                nxtSeqLen     = frameCnt_ff;
                nxtStarted    = 8'h0;
                nxtFramesRead = 8'h0;
                nxtLastRead   = 1'b0;
                nxtActive     = 1'b1;
            end
        end
    end

    // ==========================================================
    // Sequencer flip-flops
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pipe_ff        <= PS_IDLE;
            {expOn_ff, expSeen_ff, corruptPend_ff, corruptOut_ff} <= 4'h0;
            {active_ff, lastRead_ff, pixReset_ff, readStart_ff}   <= 4'h0;
            {abort_ff, sampling_ff, reading_ff}                   <= 3'h0;
            {expCnt_ff, globCnt_ff, frameTimer_ff}                <= 96'h0;
            {seqLen_ff, started_ff, framesRead_ff}                <= 24'h0;
        end
        else
        begin
            pipe_ff        <= nxtPipe;
            {expOn_ff, expSeen_ff, corruptPend_ff, corruptOut_ff} <= {nxtExpOn, nxtExpSeen, nxtCorruptPend, nxtCorruptOut};
            {active_ff, lastRead_ff, pixReset_ff, readStart_ff}   <= {nxtActive, nxtLastRead, nxtPixReset, nxtReadStart};
            {abort_ff, sampling_ff, reading_ff} <= {nxtAbort, nxtPipe == PS_GLOB, nxtPipe == PS_READ};
            {expCnt_ff, globCnt_ff, frameTimer_ff}                <= {nxtExpCnt, nxtGlobCnt, nxtFrameTimer};
            {seqLen_ff, started_ff, framesRead_ff}                <= {nxtSeqLen, nxtStarted, nxtFramesRead};
        end
    end

    assign exposing     = expOn_ff;
    assign pixelReset   = pixReset_ff;
    assign sampling     = sampling_ff;
    assign readingOut   = reading_ff;
    assign readoutStart = readStart_ff;
    assign readoutAbort = abort_ff;
    assign frameCorrupt = corruptOut_ff;
    assign seqActive    = active_ff;

    // ==========================================================
    // AXI4-Lite decode
    wire awTake  = s_axi_awvalid & awReady_ff;
    wire wTake   = s_axi_wvalid & wReady_ff;
    wire doWrite = !awReady_ff && !wReady_ff && !bValid_ff;
    wire arTake  = s_axi_arvalid & arReady_ff;
    logic [31:0] wMask;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign wMask[gi*8 +: 8] = {8{wStrb_ff[gi]}};
        end
    endgenerate
    wire selCtrl  = awAddr_ff == `IAS_OFF_CTRL;
    wire selExp   = awAddr_ff == `IAS_OFF_EXPTIME;
    wire selFrame = awAddr_ff == `IAS_OFF_FRAMETIME;
    wire selCnt   = awAddr_ff == `IAS_OFF_FRAMECNT;
    wire selGlob  = awAddr_ff == `IAS_OFF_GLOBTIME;
    wire wrHit    = selCtrl | selExp | selFrame | selCnt | selGlob | (awAddr_ff == `IAS_OFF_STATUS);
    wire [31:0] wrCnt = ({24'h0, frameCnt_ff} & ~wMask) | (wData_ff & wMask);
    wire [31:0] status = {8'h0, seqLen_ff, framesRead_ff, 2'b00, pipe_ff == PS_HOLD, corruptOut_ff,
                          active_ff, reading_ff, sampling_ff, expOn_ff};
    wire [31:0] rdMux =
        (s_axi_araddr == `IAS_OFF_CTRL)      ? ctrl_ff :
        (s_axi_araddr == `IAS_OFF_EXPTIME)   ? expTime_ff :
        (s_axi_araddr == `IAS_OFF_FRAMETIME) ? frameTime_ff :
        (s_axi_araddr == `IAS_OFF_FRAMECNT)  ? {24'h0, frameCnt_ff} :
        (s_axi_araddr == `IAS_OFF_STATUS)    ? status :
        (s_axi_araddr == `IAS_OFF_GLOBTIME)  ? globTime_ff : 32'h0;
    wire rdHit = (s_axi_araddr == `IAS_OFF_CTRL) | (s_axi_araddr == `IAS_OFF_EXPTIME) |
                 (s_axi_araddr == `IAS_OFF_FRAMETIME) | (s_axi_araddr == `IAS_OFF_FRAMECNT) |
                 (s_axi_araddr == `IAS_OFF_STATUS) | (s_axi_araddr == `IAS_OFF_GLOBTIME);

    // ==========================================================
    // AXI4-Lite slave and register file
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            {awReady_ff, wReady_ff, arReady_ff} <= 3'b111;
            {bValid_ff, rValid_ff}              <= 2'b00;
            {bResp_ff, rResp_ff}                <= 4'h0;
            awAddr_ff    <= 12'h000;
            wData_ff     <= 32'h0;
            wStrb_ff     <= 4'h0;
            rData_ff     <= 32'h0;
            ctrl_ff      <= `IAS_CTRL_RST;
            expTime_ff   <= `IAS_EXPTIME_RST;
            frameTime_ff <= `IAS_FRAMETIME_RST;
            frameCnt_ff  <= `IAS_FRAMECNT_RST;
            globTime_ff  <= `IAS_GLOBTIME_RST;
        end
        else
        begin
            if (awTake)
            begin
                awAddr_ff  <= {s_axi_awaddr[11:2], 2'b00};
                awReady_ff <= 1'b0;
            end
            if (wTake)
            begin
                wData_ff  <= s_axi_wdata;
                wStrb_ff  <= s_axi_wstrb;
                wReady_ff <= 1'b0;
            end
            if (doWrite)
            begin
                bValid_ff <= 1'b1;
                bResp_ff  <= wrHit ? `IAS_RESP_OKAY : `IAS_RESP_SLVERR;
                if (selCtrl)
                    ctrl_ff <= (ctrl_ff & ~wMask) | (wData_ff & wMask);
                if (selExp)
                    expTime_ff <= (expTime_ff & ~wMask) | (wData_ff & wMask);
                if (selFrame)
                    frameTime_ff <= (frameTime_ff & ~wMask) | (wData_ff & wMask);
                if (selCnt)
                    frameCnt_ff <= wrCnt[7:0];
                if (selGlob)
                    globTime_ff <= (globTime_ff & ~wMask) | (wData_ff & wMask);
            end
            if (bValid_ff && s_axi_bready)
            begin
                bValid_ff  <= 1'b0;
                awReady_ff <= 1'b1;
                wReady_ff  <= 1'b1;
            end
            if (arTake)
            begin
                arReady_ff <= 1'b0;
                rValid_ff  <= 1'b1;
                rData_ff   <= rdMux;
                rResp_ff   <= rdHit ? `IAS_RESP_OKAY : `IAS_RESP_SLVERR;
            end
            if (rValid_ff && s_axi_rready)
            begin
                rValid_ff  <= 1'b0;
                arReady_ff <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awReady_ff;
    assign s_axi_wready  = wReady_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bResp_ff;
    assign s_axi_arready = arReady_ff;
    assign s_axi_rvalid  = rValid_ff;
    assign s_axi_rdata   = rData_ff;
    assign s_axi_rresp   = rResp_ff;
endmodule : ias_sequencer

// file: tb/ias_sequencer_monitor.sv
// Port checker of the acquisition sequencer
// Assumes binding into ias_sequencer, one clock
`timescale 1ns/100ps
module ias_sequencer_monitor (
    // ==== Clock, reset, datapath
    input wire logic sys_clk, reset, readoutDone,
    // ==== Sequencer outputs
    input wire logic exposing, pixelReset, sampling, readingOut,
    input wire logic readoutStart, readoutAbort, frameCorrupt, seqActive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_expose_clears: assert property ($rose(exposing) |-> pixelReset)
        else $error("exposure began without charge clear");
    a_done_ends: assert property (readingOut && readoutDone |=> !readingOut)
        else $error("readout outlived done strobe");
    a_read_entry: assert property ($fell(sampling) |-> readingOut && readoutStart)
        else $error("sampling not followed by readout");
    a_start_entry: assert property ($rose(readingOut) |-> readoutStart && $past(sampling))
        else $error("readout entered without sampling");
    a_abort_glob: assert property (readoutAbort |-> sampling && !readingOut && !seqActive)
        else $error("abort did not restart sampling");
    a_glob_alone: assert property (sampling |-> !readingOut)
        else $error("sampling and readout overlap");
    a_ti_clean: assert property (seqActive |-> !frameCorrupt)
        else $error("corrupt frame in sequence");
    a_glob_span: assert property ($rose(sampling) |-> sampling [*3])
        else $error("sampling cut short");
endmodule : ias_sequencer_monitor
bind ias_sequencer ias_sequencer_monitor i_ias_sequencer_monitor (.*);

// file: tb/ias_readout_model.sv
// Readout datapath stand-in: a done strobe a fixed time after each start
// Assumes start and abort pulses on sys_clk
`timescale 1ns/100ps
module ias_readout_model #(parameter int READ_LEN = 20) (
    // ==== Clock, reset and sequencer side
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic readoutStart,
    input  wire logic readoutAbort,
    output logic      readoutDone
);
    int cnt_ff;
    always_ff @(posedge sys_clk)
    begin
        readoutDone <= 1'b0;
        if (reset || readoutAbort) // Abort drops unread data
            cnt_ff <= 0;
        else if (readoutStart)
            cnt_ff <= READ_LEN;
        else if (cnt_ff != 0)
        begin
            cnt_ff <= cnt_ff - 1;
            readoutDone <= (cnt_ff == 1); // Fixed length, not real pixels
        end
    end
endmodule : ias_readout_model

// file: tb/ias_sequencer_bench.sv
// Bench of the sequencer: bus, pin and register requests, both modes
// Assumes the readout model as datapath
`timescale 1ns/100ps
`include "ias_cfg.svh"
module ias_sequencer_bench;
    import ias_pkg::*;
    logic sys_clk = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, reqPin1 = 0, reqPin2 = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    ias_word_t s_axi_wdata = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, readoutDone;
    wire exposing, pixelReset, sampling, readingOut, readoutStart, readoutAbort, frameCorrupt, seqActive;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire ias_word_t s_axi_rdata;
    wire [7:0] st = {seqActive, pixelReset, readoutAbort, frameCorrupt, readoutStart, readingOut, sampling, exposing};
    int n_fail = 0, tests_run = 0, cyc = 0, nRd = 0, tRd = 0, gap = 0;
    ias_sequencer i_ias_sequencer (.*);
    ias_readout_model i_ias_readout_model (.*);
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (readoutStart) begin nRd <= nRd + 1; gap <= cyc - tRd; tRd <= cyc; end
        if (cyc == 20000) begin n_fail++; give_verdict(); end
    end
    // ==== Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin n_fail++; $display("Error %s expected %h seen %h", what, exp, got); end
    endtask : chk
    task automatic waitBit(input int i, input logic v);
        for (int k = 0; k < 400 && st[i] !== v; k++) @(posedge sys_clk);
        chk("state bit", {31'h0, v}, {31'h0, st[i]});
    endtask : waitBit
    task automatic axiWr(input logic [11:0] a, input ias_word_t d, input logic [1:0] er);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk("bresp", er, s_axi_bresp);
        @(posedge sys_clk);
    endtask : axiWr
    task automatic axiRd(input logic [11:0] a, input ias_word_t ed, input logic [1:0] er);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge sys_clk);
    endtask : axiRd
    task automatic pulse(input int pin);
        if (pin == 1) reqPin1 <= 1; else reqPin2 <= 1;
        repeat (4) @(posedge sys_clk);
        if (pin == 1) reqPin1 <= 0; else reqPin2 <= 0;
    endtask : pulse
    // ==== Scenarios
    task automatic test_regs();
        axiRd(`IAS_OFF_EXPTIME, `IAS_EXPTIME_RST, `IAS_RESP_OKAY);
        axiRd(12'h0fc, 32'h0, `IAS_RESP_SLVERR);
        axiWr(12'h0fc, 32'h1, `IAS_RESP_SLVERR);
        axiWr(`IAS_OFF_GLOBTIME, 32'h4, `IAS_RESP_OKAY);
        axiWr(`IAS_OFF_EXPTIME, 32'h8, `IAS_RESP_OKAY);
        axiWr(`IAS_OFF_FRAMETIME, 32'h28, `IAS_RESP_OKAY);
        axiRd(`IAS_OFF_FRAMETIME, 32'h28, `IAS_RESP_OKAY);
        $display("test regs done");
    endtask : test_regs
    task automatic test_fe();
        pulse(1); waitBit(0, 1);
        pulse(2); waitBit(1, 1);
        chk("exposing", 0, exposing);
        waitBit(3, 1); chk("corrupt", 0, frameCorrupt);
        pulse(1); waitBit(0, 1); chk("overlap", 1, readingOut);
        pulse(2); waitBit(5, 1); waitBit(3, 1); chk("corrupt", 0, frameCorrupt);
        @(posedge sys_clk); chk("frame period", 12, gap);
        pulse(2); waitBit(3, 1); chk("corrupt", 1, frameCorrupt);
        waitBit(2, 0); pulse(2); waitBit(3, 1); chk("corrupt", 1, frameCorrupt);
        waitBit(2, 0);
        $display("test fe done");
    endtask : test_fe
    task automatic test_ti();
        axiWr(`IAS_OFF_FRAMECNT, 32'h2, `IAS_RESP_OKAY);
        axiWr(`IAS_OFF_CTRL, 32'h1, `IAS_RESP_OKAY);
        nRd = 0;
        pulse(1); pulse(2); waitBit(7, 0);
        chk("frames", 2, nRd);
        chk("period", 40, gap);
        chk("hold", 1, (cyc - tRd) >= 35);
        axiWr(`IAS_OFF_FRAMETIME, 32'h1a, `IAS_RESP_OKAY);
        pulse(1); waitBit(7, 0);
        chk("top rate", 26, gap);
        $display("test ti done");
    endtask : test_ti
    task automatic test_single();
        axiWr(`IAS_OFF_CTRL, 32'h6, `IAS_RESP_OKAY);
        axiWr(`IAS_OFF_CTRL, 32'h106, `IAS_RESP_OKAY); waitBit(0, 1);
        axiWr(`IAS_OFF_CTRL, 32'h6, `IAS_RESP_OKAY); waitBit(1, 1);
        waitBit(2, 1); waitBit(2, 0);
        $display("test single done");
    endtask : test_single
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 0;
        test_regs(); test_fe(); test_ti(); test_single();
        give_verdict();
    end
endmodule : ias_sequencer_bench
